// ===== sleep_wake_watchdog_control.sv
// How it works
// - Hold core in reset about 5 ms
// - Halt gates CPU clock, interrupts resume
// - Stop ends only through a reset
// - Restart from stop at address 000C
// - Bits 3,4 keep oscillator in stop
// - Field 4:2 selects recovery source
// - Analog port3 lines never wake stop
// - SPI match wakes from stop when SPI and compare are enabled
// - Bit 5 selects delayed or fast wake
// - Bit 6 selects wake level, resets 0
// - Bit 7 warm flag, set on stop
// - Watchdog retriggerable one-shot resets device
// - First refresh enables, only power-up disables
// - Bit 4 selects watchdog clock source
// - Refresh updates zero, sign, overflow flags
// - Tap select, halt and stop run bits
// - Bits 3,4: external clock in stop
// - Config writable 64 cycles after start
// - Watchdog config write-only at 0FH
// - Stop recovery keeps configuration registers
// - Timer started by POR, timeout, slow wake
module sleep_wake_watchdog_control
   import swwd_pkg::*;
#(
   parameter int POR_CYCLES = POR_CYC,
   parameter int WD_TAP0 = 1024,
   parameter int WD_TAP1 = 2048,
   parameter int WD_TAP2 = 4096,
   parameter int WD_TAP3 = 8192
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_good,
   input wire logic [7:0] op_exec,
   input wire logic op_valid,
   input wire logic irq_any,
   input wire logic [3:1] port3_pins,
   input wire logic [7:0] port2_pins,
   input wire logic spi_enable,
   input wire logic spi_compare_en,
   input wire logic spi_match,
   input wire logic rc_osc_tick,
   input wire logic osc_input_pin,
   output logic core_reset,
   output logic cpu_clk_en,
   output logic osc_en,
   output logic [15:0] restart_addr,
   output logic [2:0] flags_zsv,
   output logic flags_we
);
   typedef struct packed {
      pstate_t st;
      logic [31:0] por_cnt;
      logic [6:0] win_cnt;
      logic [7:0] wcfg;
      logic [7:0] srec;
      logic [7:0] pmode;
      logic wd_en;
      logic [15:0] wd_cnt;
      logic rc_d, xt_d;
      logic pg_d;
      logic warm_rst;
      logic [31:0] prdata;
      logic pready, pslverr;
      logic core_reset, cpu_clk_en, osc_en;
      logic [15:0] restart_addr;
      logic [2:0] flags_zsv;
      logic flags_we;
   } state_t;
   state_t s_r, s_nxt;

   logic [3:1] p3_s;
   logic [7:0] p2_s;
   logic pg_s, spi_s, rc_s, xt_s;
   // Pins pass two flops before use
   sync2 #(.W(15)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d({port3_pins, port2_pins, power_good, spi_match, rc_osc_tick,
          osc_input_pin}),
      .q({p3_s, p2_s, pg_s, spi_s, rc_s, xt_s})
   );

   logic src_lvl, wake, wd_tick, wd_run, wd_tmo, wr, rd, analog;
   logic [15:0] tap;
   assign analog = s_r.pmode[1];
   always_comb begin
      s_nxt = s_r;
      wr = psel && penable && pwrite && s_r.pready;
      rd = psel && penable && !pwrite;
      // Recovery source select, level applied below
      case (s_r.srec[4:2])
         3'b010: src_lvl = analog ? !s_r.srec[LEVEL_BIT] : p3_s[1];
         3'b011: src_lvl = analog ? !s_r.srec[LEVEL_BIT] : p3_s[2];
         3'b100: src_lvl = analog ? !s_r.srec[LEVEL_BIT] : p3_s[3];
         3'b101: src_lvl = p2_s[7];
         3'b110: src_lvl = ~|p2_s[3:0];
         3'b111: src_lvl = ~|p2_s;
         default: src_lvl = !s_r.srec[LEVEL_BIT];
      endcase
      wake = (src_lvl == s_r.srec[LEVEL_BIT])
         || (spi_enable && spi_compare_en && spi_s);
      // Watchdog clock: RC or external edge
      wd_tick = s_r.wcfg[WD_EXT_BIT] ? (xt_s && !s_r.xt_d)
                                     : (rc_s && !s_r.rc_d);
      if (s_r.st == ST_STOP && s_r.wcfg[WD_STOP_BIT]
          && s_r.wcfg[WD_EXT_BIT])
         wd_tick = xt_s && !s_r.xt_d;
      wd_run = s_r.wd_en && (s_r.st == ST_RUN
         || (s_r.st == ST_HALT && s_r.wcfg[WD_HALT_BIT])
         || (s_r.st == ST_STOP && s_r.wcfg[WD_STOP_BIT]));
      case (s_r.wcfg[1:0])
         2'd0: tap = 16'(WD_TAP0);
         2'd1: tap = 16'(WD_TAP1);
         2'd2: tap = 16'(WD_TAP2);
         default: tap = 16'(WD_TAP3);
      endcase
      wd_tmo = wd_run && wd_tick && (s_r.wd_cnt + 16'h0001 >= tap);
      s_nxt.rc_d = rc_s;
      s_nxt.xt_d = xt_s;
      // Held high in reset so release gives no false power-up edge
      s_nxt.pg_d = pg_s || s_r.st == ST_RESET;
      s_nxt.flags_we = 1'b0;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      if (wd_run && wd_tick)
         s_nxt.wd_cnt = s_r.wd_cnt + 16'h0001;
      // APB slave, one wait state
      if (psel && penable && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = 32'h0000_0000;
         case (paddr)
            ADDR_WDOG_CFG: begin
               s_nxt.prdata = 32'h0000_0000;
            end
            ADDR_STOP_REC: begin
               if (rd)
                  s_nxt.prdata = {24'h00_0000, s_r.srec};
            end
            ADDR_STATUS: begin
               if (rd)
                  s_nxt.prdata = {24'h00_0000, s_r.wd_en, s_r.win_cnt};
            end
            ADDR_PORT_MODE: begin
               if (rd)
                  s_nxt.prdata = {24'h00_0000, s_r.pmode};
            end
            default: s_nxt.pslverr = 1'b1;
         endcase
      end
      // Writes land on the edge that completes the transfer
      if (wr) begin
         case (paddr)
            ADDR_WDOG_CFG: begin
               // Write-only, window-gated
               if (s_r.win_cnt < 7'(CFG_WINDOW_CYC)
                   && s_r.st == ST_RUN)
                  s_nxt.wcfg = pwdata[7:0] & WD_CFG_MASK;
            end
            ADDR_STOP_REC: s_nxt.srec[6:0] = pwdata[6:0];
            ADDR_PORT_MODE: s_nxt.pmode = pwdata[7:0];
            default: s_nxt.pmode = s_r.pmode;
         endcase
      end
      if (s_r.st == ST_RUN && s_r.win_cnt < 7'(CFG_WINDOW_CYC))
         s_nxt.win_cnt = s_r.win_cnt + 7'h01;
      case (s_r.st)
         ST_RESET: begin
            s_nxt.core_reset = 1'b1;
            s_nxt.cpu_clk_en = 1'b0;
            s_nxt.osc_en = 1'b1;
            if (s_r.por_cnt != 32'h0000_0000)
               s_nxt.por_cnt = s_r.por_cnt - 32'h0000_0001;
            else begin
               s_nxt.st = ST_RUN;
               s_nxt.core_reset = 1'b0;
               s_nxt.cpu_clk_en = 1'b1;
               s_nxt.win_cnt = 7'h00;
            end
         end
         ST_RUN: begin
            if (op_valid && op_exec == OP_HALT) begin
               s_nxt.st = ST_HALT;
               s_nxt.cpu_clk_en = 1'b0;
            end else if (op_valid && op_exec == OP_STOP) begin
               s_nxt.st = ST_STOP;
               s_nxt.cpu_clk_en = 1'b0;
               s_nxt.srec[WARM_BIT] = 1'b1;
               // Crystal kept only for external watchdog
               s_nxt.osc_en = s_r.wcfg[WD_STOP_BIT]
                  && s_r.wcfg[WD_EXT_BIT];
            end else if (op_valid && op_exec == 8'h5f) begin
               // Refresh: enable and restart, flag update
               s_nxt.wd_en = 1'b1;
               s_nxt.wd_cnt = 16'h0000;
               s_nxt.flags_zsv = 3'b100;
               s_nxt.flags_we = 1'b1;
            end
         end
         ST_HALT: begin
            if (irq_any) begin
               s_nxt.st = ST_RUN;
               s_nxt.cpu_clk_en = 1'b1;
            end
         end
         ST_STOP: begin
            // Only a reset leaves stop
            if (wake) begin
               s_nxt.restart_addr = RESTART_VECTOR;
               s_nxt.osc_en = 1'b1;
               s_nxt.st = ST_RESET;
               s_nxt.core_reset = 1'b1;
               s_nxt.por_cnt = s_r.srec[DELAY_BIT]
                  ? 32'(POR_CYCLES) : 32'h0000_0000;
            end
         end
         default: s_nxt.st = ST_RESET;
      endcase
      // Watchdog timeout or power-good edge: full reset
      if (wd_tmo || (pg_s && !s_r.pg_d)) begin
         s_nxt.st = ST_RESET;
         s_nxt.core_reset = 1'b1;
         s_nxt.cpu_clk_en = 1'b0;
         s_nxt.osc_en = 1'b1;
         s_nxt.por_cnt = 32'(POR_CYCLES);
         s_nxt.srec[WARM_BIT] = 1'b0;
         s_nxt.wd_cnt = 16'h0000;
         s_nxt.restart_addr = 16'h0000;
         if (pg_s && !s_r.pg_d) begin
            // Power-up reloads; stop recovery never gets here
            s_nxt.wcfg = WDOG_CFG_RST;
            s_nxt.srec = STOP_REC_RST;
            s_nxt.pmode = 8'h00;
            s_nxt.wd_en = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
         s_r.st <= ST_RESET;
         s_r.por_cnt <= 32'(POR_CYCLES);
         s_r.srec <= STOP_REC_RST;
         s_r.core_reset <= 1'b1;
         s_r.osc_en <= 1'b1;
         s_r.pg_d <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign core_reset = s_r.core_reset;
   assign cpu_clk_en = s_r.cpu_clk_en;
   assign osc_en = s_r.osc_en;
   assign restart_addr = s_r.restart_addr;
   assign flags_zsv = s_r.flags_zsv;
   assign flags_we = s_r.flags_we;

   AST_STOP_NO_CPU: assert property (@(posedge clk) disable iff (!arst_n)
      s_r.st == ST_STOP |-> !cpu_clk_en) else $error("cpu clock in stop");
   AST_HALT_GATE: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(s_r.st == ST_HALT) |-> !cpu_clk_en && osc_en)
      else $error("halt gating wrong");
   AST_RESTART_VEC: assert property (@(posedge clk) disable iff (!arst_n)
      s_r.st == ST_STOP ##1 s_r.st == ST_RESET |-> restart_addr == 16'h000c)
      else $error("bad restart address");
   AST_OSC_STOP: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(s_r.st == ST_STOP) |-> osc_en == (s_r.wcfg[3] && s_r.wcfg[4]))
      else $error("oscillator in stop wrong");
   AST_WARM_SET: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(s_r.st == ST_STOP) |-> s_r.srec[7])
      else $error("warm flag not set");
   AST_WD_STICKY: assert property (@(posedge clk) disable iff (!arst_n)
      s_r.wd_en && !$rose(pg_s) |=> s_r.wd_en)
      else $error("watchdog disabled");
   AST_CFG_LOCK: assert property (@(posedge clk) disable iff (!arst_n)
      s_r.win_cnt >= 7'd64 && s_r.st == ST_RUN |=> $stable(s_r.wcfg))
      else $error("config changed after window");
   AST_FAST_WAKE: assert property (@(posedge clk) disable iff (!arst_n)
      s_r.st == ST_STOP && wake && !s_r.srec[5] |=> ##1 !core_reset)
      else $error("fast wake slow");
   AST_FLAGS: assert property (@(posedge clk) disable iff (!arst_n)
      s_r.st == ST_RUN && op_valid && op_exec == 8'h5f |=> flags_we)
      else $error("flags not updated");
endmodule

// ===== swwd_pkg.sv
package swwd_pkg;
   // APB register index and byte addresses
   localparam logic [11:0] WDOG_CFG_IDX = 12'h00f;
   localparam logic [11:0] ADDR_WDOG_CFG = 12'h03c;
   localparam logic [11:0] ADDR_STOP_REC = 12'h040;
   localparam logic [11:0] ADDR_STATUS = 12'h044;
   localparam logic [11:0] ADDR_PORT_MODE = 12'h048;
   // Recovery config fields
   localparam int SRC_LSB = 2;
   localparam int DELAY_BIT = 5;
   localparam int LEVEL_BIT = 6;
   localparam int WARM_BIT = 7;
   localparam logic [7:0] STOP_REC_RST = 8'h20;
   localparam logic [7:0] WDOG_CFG_RST = 8'h00;
   // Watchdog config fields
   localparam int WD_HALT_BIT = 2;
   localparam int WD_STOP_BIT = 3;
   localparam int WD_EXT_BIT = 4;
   localparam logic [7:0] WD_CFG_MASK = 8'h1f;
   localparam logic [15:0] RESTART_VECTOR = 16'h000c;
   localparam int CLK_MHZ = 100;
   localparam int POR_US = 5000;
   localparam int POR_CYC = POR_US * CLK_MHZ;
   localparam int CFG_WINDOW_CYC = 64;
   localparam logic [7:0] OP_FLUSH = 8'hff;
   localparam logic [7:0] OP_STOP = 8'h6f;
   localparam logic [7:0] OP_HALT = 8'h7f;
   typedef enum logic [3:0] {
      ST_RESET = 4'b0001,
      ST_RUN = 4'b0010,
      ST_HALT = 4'b0100,
      ST_STOP = 4'b1000
   } pstate_t;
endpackage

// ===== sync2.sv
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] m_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         m_r <= '0;
         q <= '0;
      end else begin
         m_r <= d;
         q <= m_r;
      end
   end
endmodule

// ===== core_model.sv
module core_model
   import swwd_pkg::*;
(
   input wire logic clk,
   output logic [7:0] op_exec,
   output logic op_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      op_exec = 8'h00;
      op_valid = 1'b0;
   end
   task automatic issue(input logic [7:0] op);
      op_exec <= op;
      op_valid <= 1'b1;
      @(posedge clk);
      op_valid <= 1'b0;
   endtask
   // Flush op straight before sleep so no opcode is cut in half
   task automatic sleep(input logic [7:0] op);
      op_exec <= OP_FLUSH;
      op_valid <= 1'b1;
      @(posedge clk);
      op_exec <= op;
      @(posedge clk);
      op_valid <= 1'b0;
   endtask
endmodule

// ===== sleep_wake_watchdog_control_bench.sv
module sleep_wake_watchdog_control_bench
   import swwd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int POR = 20;
   typedef struct packed {
      logic [7:0] cfg, pm, p2i, p2w;
      logic [2:0] p3i, p3w;
      logic spi, wk;
   } row_t;
   logic clk, arst_n, psel, penable, pwrite, pready, pslverr, power_good;
   logic op_valid, irq_any, spi_enable, spi_compare_en, spi_match;
   logic rc_osc_tick, osc_input_pin, core_reset, cpu_clk_en, osc_en;
   logic flags_we;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, lfsr;
   logic [7:0] op_exec, port2_pins;
   logic [2:0] port3_pins, flags_zsv;
   logic [15:0] restart_addr;
   logic [32:0] exp_q[$];
   int miscompares, total_checks, cyc, n;
   row_t rows [4] = '{'{8'h54, 8'h00, 8'h00, 8'h80, 3'h0, 3'h0, 1'b0, 1'b1},
      '{8'h08, 8'h02, 8'hff, 8'hff, 3'h7, 3'h0, 1'b0, 1'b0},
      '{8'h08, 8'h02, 8'hff, 8'hff, 3'h7, 3'h0, 1'b1, 1'b1},
      '{8'h7c, 8'h00, 8'h01, 8'h00, 3'h0, 3'h0, 1'b0, 1'b1}};

   core_model core (.clk(clk), .op_exec(op_exec), .op_valid(op_valid));
   sleep_wake_watchdog_control #(.POR_CYCLES(POR), .WD_TAP0(16),
      .WD_TAP1(32), .WD_TAP2(64), .WD_TAP3(128)) dut (
      .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .power_good(power_good),
      .op_exec(op_exec), .op_valid(op_valid), .irq_any(irq_any),
      .port3_pins(port3_pins), .port2_pins(port2_pins),
      .spi_enable(spi_enable), .spi_compare_en(spi_compare_en),
      .spi_match(spi_match), .rc_osc_tick(rc_osc_tick),
      .osc_input_pin(osc_input_pin), .core_reset(core_reset),
      .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
      .restart_addr(restart_addr), .flags_zsv(flags_zsv),
      .flags_we(flags_we));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check_sig(input string nm, input logic [32:0] e,
      input logic [32:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Bit 32 of a read note marks an expected error, data then unchecked
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [7:0] d, input logic [32:0] e);
      int k;
      if (!wr) exp_q.push_back(e);
      lfsr = nxt(lfsr);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {lfsr[23:0], d};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) miscompares++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_sel(input int sel, input int lim, output int c);
      logic v;
      c = 0;
      do begin
         @(posedge clk);
         c++;
         v = sel == 0 ? core_reset : sel == 1 ? cpu_clk_en & ~core_reset :
            sel == 2 ? flags_we : ~core_reset;
      end while (v !== 1'b1 && c < lim);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      rc_osc_tick <= ~rc_osc_tick;
      osc_input_pin <= ~osc_input_pin;
   end
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         check_sig("pslverr", {32'h0, exp_q[0][32]}, {32'h0, pslverr});
         if (!exp_q[0][32]) check_sig("prdata", exp_q[0][31:0], prdata);
         void'(exp_q.pop_front());
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         miscompares++;
         wrap_up;
      end
   end

   initial begin
      {arst_n, psel, penable, pwrite, irq_any, spi_enable} = '0;
      {spi_compare_en, spi_match, rc_osc_tick, osc_input_pin} = '0;
      paddr = '0;
      pwdata = '0;
      port2_pins = '0;
      port3_pins = '0;
      power_good = 1'b1;
      lfsr = 32'h0000_7e5a;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      wait_sel(3, 40, n);
      check_sig("reset_len", 1, n >= POR + 1 && n <= POR + 3);
      apb(1, ADDR_WDOG_CFG, 8'h04, 0);
      apb(0, ADDR_WDOG_CFG, 0, 0);
      apb(0, ADDR_STOP_REC, 0, 33'h0_0000_0020);
      apb(0, 12'h0f0, 0, {1'b1, 32'h0});
      $display("test reset and registers done");
      core.sleep(OP_HALT);
      repeat (3) @(posedge clk);
      check_sig("halt_clk", 0, cpu_clk_en);
      check_sig("halt_osc", 1, osc_en);
      irq_any <= 1'b1;
      wait_sel(1, 10, n);
      check_sig("halt_resume", 1, n < 10);
      irq_any <= 1'b0;
      $display("test halt done");
      foreach (rows[i]) begin
         @(posedge clk);
         if (cpu_clk_en === 1'b1) begin
            apb(1, ADDR_STOP_REC, rows[i].cfg, 0);
            apb(1, ADDR_PORT_MODE, rows[i].pm, 0);
            port2_pins <= rows[i].p2i;
            port3_pins <= rows[i].p3i;
            core.sleep(OP_STOP);
            repeat (4) @(posedge clk);
            check_sig("stop_osc", 0, osc_en);
         end
         lfsr = nxt(lfsr);
         port2_pins <= rows[i].p2w;
         port3_pins <= rows[i].p3w;
         {spi_enable, spi_compare_en, spi_match} <= {3{rows[i].spi}};
         irq_any <= lfsr[0];
         wait_sel(1, 80, n);
         check_sig("wake", rows[i].wk, n < 80);
         irq_any <= 1'b0;
         {spi_enable, spi_compare_en, spi_match} <= 3'b000;
         if (rows[i].wk) begin
            check_sig("restart", RESTART_VECTOR, restart_addr);
            check_sig("slow", rows[i].cfg[5], n > POR);
            apb(0, ADDR_STOP_REC, 0, {25'h0, rows[i].cfg | 8'h80});
         end
         $display("test stop row %0d done", i);
      end
      core.issue(8'h5f);
      wait_sel(2, 4, n);
      check_sig("flags_we", 1, n < 4);
      wait_sel(0, 400, n);
      check_sig("wd_reset", 1, n < 400);
      wait_sel(1, 60, n);
      apb(0, ADDR_STOP_REC, 0, 33'h0_0000_007c);
      $display("test watchdog done");
      repeat (2) @(posedge clk);
      wrap_up;
   end
endmodule
